/* File: rtl/agmt_params.svh */
// Register offsets, reset values, field layout and timing counts of the gain, mix and tone path
`ifndef AGMT_PARAMS_SVH
`define AGMT_PARAMS_SVH
// Control port subaddresses
`define AGMT_SUB_VOLUME    8'h04
`define AGMT_SUB_TREBLE    8'h05
`define AGMT_SUB_BASS      8'h06
`define AGMT_SUB_MIX_LEFT  8'h07
`define AGMT_SUB_MIX_RIGHT 8'h08
`define AGMT_SUB_MUTE      8'h0A
// Payload lengths in bytes
`define AGMT_LEN_VOLUME    4'd6
`define AGMT_LEN_TONE      4'd1
`define AGMT_LEN_MIX       4'd9
`define AGMT_LEN_MUTE      4'd1
// Mixer payload field positions (first serial input sent first)
`define AGMT_MIX_IN1_LSB   48
`define AGMT_MIX_IN2_LSB   24
`define AGMT_MIX_ADC_LSB   0
// Reset values
`define AGMT_RST_VOLUME    20'h10000
`define AGMT_RST_MIX_IN1   24'h100000
`define AGMT_RST_MIX_OTHER 24'h000000
`define AGMT_RST_TONE      8'h00
// Soft volume ramp length is 2048 samples
`define AGMT_RAMP_SHIFT    11
`define AGMT_RAMP_ROUND    20'h007FF
// Tone code range in half-decibel steps, full and pin-driven
`define AGMT_TONE_MAX      8'sd30
`define AGMT_TONE_GPI_MAX  8'sd12
// Half-decibel factors, Q20, and unity
`define AGMT_HALF_DB_UP    26'h010F2B5
`define AGMT_HALF_DB_DN    26'h00F1ADF
`define AGMT_UNITY_Q20     26'h0100000
// One-pole coefficients, Q20, for 250 Hz and 6 kHz at 48 kHz
`define AGMT_ALPHA_BASS    26'h00083E4
`define AGMT_ALPHA_TREBLE  26'h008B49F
// Pin-driven volume limits, 4.16
`define AGMT_GPI_VOL_MAX   20'h10000
`define AGMT_GPI_VOL_MIN   20'h00400
// Pin positions in the input pin vector
`define AGMT_PIN_VOL_UP    0
`define AGMT_PIN_VOL_DN    1
`define AGMT_PIN_MUTE      2
`define AGMT_PIN_TREB_UP   3
`define AGMT_PIN_TREB_DN   4
`define AGMT_PIN_BASS_UP   5
`define AGMT_PIN_BASS_DN   6
`endif

/* File: rtl/agmt_pkg.sv */
// Types and shared arithmetic of the gain, mix and tone path
package agmt_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_MIX  = 5'h02,
        ST_TONE = 5'h04,
        ST_VOL  = 5'h08,
        ST_PUSH = 5'h10
    } agmt_state_t;

    typedef struct packed {
        agmt_state_t              st;
        logic [6:0]               gs1;
        logic [6:0]               gs2;
        logic [6:0]               gprev;
        logic [7:0]               sub;
        logic [3:0]               cnt;
        logic                     first;
        logic [71:0]              sh;
        logic [1:0][71:0]         mixg;
        logic [1:0][19:0]         vset;
        logic [1:0][19:0]         vcur;
        logic [1:0][19:0]         vstep;
        logic [1:0][19:0]         vlast;
        logic                     mute;
        logic signed [7:0]        treb;
        logic signed [7:0]        bass;
        logic signed [25:0]       kt;
        logic signed [25:0]       kb;
        logic [5:0][23:0]         raw;
        logic [1:0][23:0]         sum;
        logic [1:0][23:0]         res;
        logic [23:0]              mono;
        logic                     ramping;
    } agmt_core_t;

    typedef struct packed {
        logic signed [23:0] lpb;
        logic signed [23:0] lpt;
        logic signed [23:0] y;
    } agmt_tone_t;

    typedef struct packed {
        logic [71:0] e0;
        logic [71:0] e1;
        logic [1:0]  cnt;
    } agmt_buf_t;

    // Signed sample times signed Q20 gain, scaled back
    function automatic logic signed [49:0] agmt_mulw(input logic signed [23:0] x,
                                                     input logic signed [25:0] g);
        agmt_mulw = (50'(x) * 50'(g)) >>> 20;
    endfunction : agmt_mulw

    // Clamp a wide result to the 24-bit sample range
    function automatic logic signed [23:0] agmt_sat(input logic signed [51:0] v);
        if (v > 52'sh7FFFFF)
            agmt_sat = 24'sh7FFFFF;
        else if (v < -52'sh800000)
            agmt_sat = 24'sh800000;
        else
            agmt_sat = v[23:0];
    endfunction : agmt_sat
endpackage : agmt_pkg

/* File: rtl/agmt_tone.sv */
// Bass and treble shelf pair for one channel
`timescale 1ns/100ps
`include "agmt_params.svh"
module agmt_tone
    import agmt_pkg::*;
(
    // Clock and reset
    input  logic               clk_sys,
    input  logic               rst,
    input  logic               ce,
    // Sample in
    input  logic               strobe,
    input  logic signed [23:0] x,
    // Shelf gains minus one, Q20
    input  logic signed [25:0] kb,
    input  logic signed [25:0] kt,
    // Sample out, valid the cycle after strobe
    output logic signed [23:0] y
);
    agmt_tone_t r_reg;
    agmt_tone_t r_next;
    logic signed [51:0] acc;

    // Low shelf adds scaled low band, high shelf adds scaled high band
    always_comb begin
        r_next = r_reg;
        acc    = 52'(x) + 52'(agmt_mulw(r_reg.lpb, kb))                   // [RULE_18] [RULE_19]
               + 52'(agmt_mulw(agmt_sat(52'(x) - 52'(r_reg.lpt)), kt));    // [RULE_16] [RULE_17]
        if (strobe) begin
            r_next.y   = agmt_sat(acc);                                   // [RULE_21]
            r_next.lpb = agmt_sat(52'(r_reg.lpb)
                       + 52'(agmt_mulw(agmt_sat(52'(x) - 52'(r_reg.lpb)), `AGMT_ALPHA_BASS)));
            r_next.lpt = agmt_sat(52'(r_reg.lpt)
                       + 52'(agmt_mulw(agmt_sat(52'(x) - 52'(r_reg.lpt)), `AGMT_ALPHA_TREBLE)));
        end
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            r_reg <= '0;
        else if (ce)
            r_reg <= r_next;
    end

    assign y = r_reg.y;
endmodule : agmt_tone

/* File: rtl/agmt_buf.sv */
// Two-entry output buffer with valid and ready on both sides
`timescale 1ns/100ps
module agmt_buf
    import agmt_pkg::*;
(
    // Clock and reset
    input  logic        clk_sys,
    input  logic        rst,
    input  logic        ce,
    // Fill side
    input  logic        in_valid,
    output logic        in_ready,
    input  logic [71:0] in_data,
    // Drain side
    output logic        out_valid,
    input  logic        out_ready,
    output logic [71:0] out_data
);
    agmt_buf_t b_reg;
    agmt_buf_t b_next;
    logic      push;
    logic      pop;

    // Head entry drives the output directly
    always_comb begin
        b_next = b_reg;
        push   = in_valid && (b_reg.cnt != 2'd2);
        pop    = out_ready && (b_reg.cnt != 2'd0);
        if (pop) begin
            b_next.e0 = b_reg.e1;
        end
        case ({push, pop})
            2'b10: begin
                if (b_reg.cnt == 2'd0)
                    b_next.e0 = in_data;
                else
                    b_next.e1 = in_data;
                b_next.cnt = b_reg.cnt + 2'd1;
            end
            2'b01: b_next.cnt = b_reg.cnt - 2'd1;
            2'b11: begin
                if (b_reg.cnt == 2'd1)
                    b_next.e0 = in_data;
                else
                    b_next.e1 = in_data;
            end
            default: b_next.cnt = b_reg.cnt;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            b_reg <= '0;
        else if (ce)
            b_reg <= b_next;
    end

    assign in_ready  = (b_reg.cnt != 2'd2);
    assign out_valid = (b_reg.cnt != 2'd0);
    assign out_data  = b_reg.e0;
endmodule : agmt_buf

/* File: rtl/agmt_top.sv */
// Gain, mix, mono mix, tone and soft volume path with its control registers
//
// Contract
// [RULE_01] Channel volume comes from a 4.16 gain loaded over the control port.
// [RULE_02] Volume spans +18 dB down to -70 dB in half-dB steps, then mute.
// [RULE_03] A new volume is reached by a gradual ramp, never a jump.
// [RULE_04] Left and right volumes are held apart, giving balance.
// [RULE_05] Volume is set over the control port or by up/down pins, pins limited.
// [RULE_06] An all-zero volume ramps the output to exactly zero in 2048 samples.
// [RULE_07] Soft mute starts from the mute pin or a mute command.
// [RULE_08] Each channel mixes both serial inputs and the converter, each with its gain.
// [RULE_09] Left mixer gains sit in one register, right in another, one group per source.
// [RULE_10] Mixer gains are fixed point, four integer and twenty fraction bits.
// [RULE_11] Any positive mixer gain value is accepted, not only tabled ones.
// [RULE_12] A zero mixer gain removes that source entirely.
// [RULE_13] Mixer gains act at once without ramp; the controller ramps via volume.
// [RULE_14] Mono mix adds left and right sums at -6 dB, so it cannot clip.
// [RULE_15] The mono result leaves on the mono serial output.
// [RULE_16] Treble runs -15 to +15 dB in half-dB steps from its register.
// [RULE_17] Treble corner is 6 kHz at 48 kHz sampling.
// [RULE_18] Bass runs -15 to +15 dB in half-dB steps from its register.
// [RULE_19] Bass is a shelf with a 250 Hz corner at 48 kHz sampling.
// [RULE_20] Pins can also move treble and bass, over a limited range only.
// [RULE_21] Every gain, mix and filter result saturates instead of wrapping.
`timescale 1ns/100ps
`include "agmt_params.svh"
module agmt_top
    import agmt_pkg::*;
(
    // Clock, reset, enable
    input  logic        clk_sys,
    input  logic        rst,
    input  logic        ce,
    // Control port byte stream
    input  logic        cmd_start,
    input  logic        cmd_valid,
    input  logic [7:0]  cmd_byte,
    // Input sample words at fs
    input  logic        fs_tick,
    input  logic [23:0] first_serial_input_l,
    input  logic [23:0] first_serial_input_r,
    input  logic [23:0] second_serial_input_l,
    input  logic [23:0] second_serial_input_r,
    input  logic [23:0] adc_l,
    input  logic [23:0] adc_r,
    output logic        sample_ready,
    // General purpose input pins
    input  logic [6:0]  general_purpose_input_pin,
    // Processed output words
    output logic        out_valid,
    input  logic        out_ready,
    output logic [23:0] out_l,
    output logic [23:0] out_r,
    output logic [23:0] mono_serial_output,
    // Status
    output logic        vol_ramping
);
    agmt_core_t         c_reg;
    agmt_core_t         c_next;
    logic signed [23:0] tone_y [2];
    logic               buf_in_ready;
    logic [71:0]        buf_out;
    logic [7:0]         gpi_rise;
    logic [3:0]         len;
    logic [19:0]        eff;
    logic [19:0]        diff;
    logic [19:0]        vol_adj;
    logic signed [51:0] acc;

    // Payload length of a subaddress, zero when unmapped
    function automatic logic [3:0] sub_len(input logic [7:0] s);
        case (s)
            `AGMT_SUB_VOLUME:    sub_len = `AGMT_LEN_VOLUME;
            `AGMT_SUB_TREBLE:    sub_len = `AGMT_LEN_TONE;
            `AGMT_SUB_BASS:      sub_len = `AGMT_LEN_TONE;
            `AGMT_SUB_MIX_LEFT:  sub_len = `AGMT_LEN_MIX;
            `AGMT_SUB_MIX_RIGHT: sub_len = `AGMT_LEN_MIX;
            `AGMT_SUB_MUTE:      sub_len = `AGMT_LEN_MUTE;
            default:             sub_len = 4'd0;
        endcase
    endfunction : sub_len

    // Tone code in half-dB steps to shelf gain minus one, Q20
    function automatic logic signed [25:0] tone_k(input logic signed [7:0] code);
        logic [51:0] g;
        logic [7:0]  n;
        g = 52'(`AGMT_UNITY_Q20);
        n = code[7] ? 8'(-code) : code;
        for (int i = 0; i < 30; i++) begin
            if (8'(i) < n)
                g = 52'((g * 52'(code[7] ? `AGMT_HALF_DB_DN : `AGMT_HALF_DB_UP)) >> 20);
        end
        tone_k = 26'(g[25:0] - `AGMT_UNITY_Q20);
    endfunction : tone_k

    // Clamp a tone code to a symmetric limit
    function automatic logic signed [7:0] tone_clamp(input logic signed [8:0] v,
                                                     input logic signed [7:0] lim);
        if (v > 9'(lim))
            tone_clamp = lim;
        else if (v < -9'(lim))
            tone_clamp = -lim;
        else
            tone_clamp = v[7:0];
    endfunction : tone_clamp

    // Move one ramp step toward the target, never past it
    function automatic logic [19:0] ramp_step(input logic [19:0] cur, input logic [19:0] tgt,
                                              input logic [19:0] stp);
        if (cur < tgt)
            ramp_step = (tgt - cur > stp) ? cur + stp : tgt;
        else if (cur > tgt)
            ramp_step = (cur - tgt > stp) ? cur - stp : tgt;
        else
            ramp_step = cur;
    endfunction : ramp_step

    // Rising edges on pins seen after two synchroniser stages
    assign gpi_rise = {1'b0, c_reg.gs2 & ~c_reg.gprev};

    always_comb begin
        c_next  = c_reg;
        len     = sub_len(c_reg.sub);
        eff     = '0;
        diff    = '0;
        vol_adj = '0;
        acc     = '0;

        // Pin synchronisers and edge history
        c_next.gs1   = general_purpose_input_pin;
        c_next.gs2   = c_reg.gs1;
        c_next.gprev = c_reg.gs2;

        // Control port: subaddress first, then payload bytes, commit on last byte
        if (cmd_start) begin
            c_next.first = 1'b1;
            c_next.cnt   = '0;
        end else if (cmd_valid) begin
            if (c_reg.first) begin
                c_next.sub   = cmd_byte;
                c_next.first = 1'b0;
                c_next.cnt   = '0;
            end else if (len != 4'd0 && c_reg.cnt < len) begin
                c_next.sh  = {c_reg.sh[63:0], cmd_byte};
                c_next.cnt = c_reg.cnt + 4'd1;
                if (c_reg.cnt + 4'd1 == len) begin
                    case (c_reg.sub)
                        `AGMT_SUB_VOLUME: begin
                            c_next.vset[0] = c_reg.sh[35:16];               // [RULE_01] [RULE_04]
                            c_next.vset[1] = {c_reg.sh[11:0], cmd_byte};    // [RULE_04]
                        end
                        `AGMT_SUB_TREBLE:    c_next.treb = tone_clamp(9'(signed'(cmd_byte)),
                                                               `AGMT_TONE_MAX);         // [RULE_16]
                        `AGMT_SUB_BASS:      c_next.bass = tone_clamp(9'(signed'(cmd_byte)),
                                                               `AGMT_TONE_MAX);         // [RULE_18]
                        `AGMT_SUB_MIX_LEFT:  c_next.mixg[0] = {c_reg.sh[63:0], cmd_byte}; // [RULE_09]
                        `AGMT_SUB_MIX_RIGHT: c_next.mixg[1] = {c_reg.sh[63:0], cmd_byte}; // [RULE_09]
                        `AGMT_SUB_MUTE:      c_next.mute = cmd_byte[0];                 // [RULE_07]
                        default:             c_next.mute = c_reg.mute;
                    endcase
                end
            end
        end

        // Pin-driven volume steps of about half a decibel, limited window
        for (int ch = 0; ch < 2; ch++) begin
            vol_adj = c_next.vset[ch];
            if (gpi_rise[`AGMT_PIN_VOL_UP] && vol_adj < `AGMT_GPI_VOL_MAX)
                vol_adj = vol_adj + (vol_adj >> 4) + 20'h1;                   // [RULE_05]
            if (gpi_rise[`AGMT_PIN_VOL_DN] && vol_adj > `AGMT_GPI_VOL_MIN)
                vol_adj = vol_adj - (vol_adj >> 4);                           // [RULE_05]
            c_next.vset[ch] = vol_adj;
        end

        // Pin-driven tone steps, limited subset of the range
        if (gpi_rise[`AGMT_PIN_TREB_UP])
            c_next.treb = tone_clamp(9'(c_next.treb) + 9'sd1, `AGMT_TONE_GPI_MAX);  // [RULE_20]
        if (gpi_rise[`AGMT_PIN_TREB_DN])
            c_next.treb = tone_clamp(9'(c_next.treb) - 9'sd1, `AGMT_TONE_GPI_MAX);  // [RULE_20]
        if (gpi_rise[`AGMT_PIN_BASS_UP])
            c_next.bass = tone_clamp(9'(c_next.bass) + 9'sd1, `AGMT_TONE_GPI_MAX);  // [RULE_20]
        if (gpi_rise[`AGMT_PIN_BASS_DN])
            c_next.bass = tone_clamp(9'(c_next.bass) - 9'sd1, `AGMT_TONE_GPI_MAX);  // [RULE_20]

        // Shelf gains follow the codes
        c_next.kt = tone_k(c_reg.treb);                                        // [RULE_16]
        c_next.kb = tone_k(c_reg.bass);                                        // [RULE_18]

        // Ramp step chosen so any change completes within 2048 samples
        for (int ch = 0; ch < 2; ch++) begin
            eff = (c_reg.mute || c_reg.gs2[`AGMT_PIN_MUTE]) ? 20'h0 : c_reg.vset[ch]; // [RULE_07]
            if (eff != c_reg.vlast[ch]) begin
                diff = (eff > c_reg.vcur[ch]) ? eff - c_reg.vcur[ch] : c_reg.vcur[ch] - eff;
                c_next.vstep[ch] = 20'(({1'b0, diff} + `AGMT_RAMP_ROUND)
                                       >> `AGMT_RAMP_SHIFT);                  // [RULE_06]
                c_next.vlast[ch] = eff;
            end
        end
        c_next.ramping = (c_reg.vcur[0] != c_reg.vlast[0]) || (c_reg.vcur[1] != c_reg.vlast[1]);

        // Sample sequencer
        case (c_reg.st)
            ST_IDLE: begin
                if (fs_tick) begin
                    c_next.raw = {adc_r, adc_l, second_serial_input_r, second_serial_input_l,
                                  first_serial_input_r, first_serial_input_l};
                    c_next.st  = ST_MIX;
                end
            end
            ST_MIX: begin
                for (int ch = 0; ch < 2; ch++) begin
                    acc = 52'(agmt_mulw(c_reg.raw[ch],
                              {2'b00, c_reg.mixg[ch][`AGMT_MIX_IN1_LSB +: 24]}))  // [RULE_08] [RULE_10]
                        + 52'(agmt_mulw(c_reg.raw[ch + 2],
                              {2'b00, c_reg.mixg[ch][`AGMT_MIX_IN2_LSB +: 24]}))  // [RULE_11] [RULE_12]
                        + 52'(agmt_mulw(c_reg.raw[ch + 4],
                              {2'b00, c_reg.mixg[ch][`AGMT_MIX_ADC_LSB +: 24]})); // [RULE_13]
                    c_next.sum[ch] = agmt_sat(acc);                                 // [RULE_21]
                end
                c_next.st = ST_TONE;
            end
            ST_TONE: begin
                acc = 52'(signed'(c_reg.sum[0])) + 52'(signed'(c_reg.sum[1]));
                c_next.mono = agmt_sat(acc >>> 1);                                  // [RULE_14]
                c_next.st   = ST_VOL;
            end
            ST_VOL: begin
                for (int ch = 0; ch < 2; ch++) begin
                    c_next.res[ch]  = agmt_sat(52'(agmt_mulw(tone_y[ch],
                                          {2'b00, c_reg.vcur[ch], 4'h0})));         // [RULE_02] [RULE_21]
                    c_next.vcur[ch] = ramp_step(c_reg.vcur[ch], c_reg.vlast[ch],
                                                c_reg.vstep[ch]);                   // [RULE_03] [RULE_06]
                end
                c_next.st = ST_PUSH;
            end
            ST_PUSH: begin
                if (buf_in_ready)
                    c_next.st = ST_IDLE;
            end
            default: c_next.st = ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            c_reg         <= '0;
            c_reg.st      <= ST_IDLE;
            c_reg.vset    <= {`AGMT_RST_VOLUME, `AGMT_RST_VOLUME};
            c_reg.vcur    <= {`AGMT_RST_VOLUME, `AGMT_RST_VOLUME};
            c_reg.vlast   <= {`AGMT_RST_VOLUME, `AGMT_RST_VOLUME};
            c_reg.mixg[0] <= {`AGMT_RST_MIX_IN1, `AGMT_RST_MIX_OTHER, `AGMT_RST_MIX_OTHER};
            c_reg.mixg[1] <= {`AGMT_RST_MIX_IN1, `AGMT_RST_MIX_OTHER, `AGMT_RST_MIX_OTHER};
            c_reg.treb    <= `AGMT_RST_TONE;
            c_reg.bass    <= `AGMT_RST_TONE;
        end else if (ce) begin
            c_reg <= c_next;
        end
    end

    // Per-channel bass and treble shelves, strobed as the mix sums settle
    for (genvar ch = 0; ch < 2; ch++) begin : g_tone
        agmt_tone u_tone (
            .clk_sys (clk_sys),
            .rst     (rst),
            .ce      (ce),
            .strobe  (c_reg.st == ST_TONE),
            .x       (c_reg.sum[ch]),
            .kb      (c_reg.kb),
            .kt      (c_reg.kt),
            .y       (tone_y[ch])
        );
    end

    // Output buffer; with both entries full, a stalled receiver holds the sequencer in its push state
    agmt_buf u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (c_reg.st == ST_PUSH),
        .in_ready  (buf_in_ready),
        .in_data   ({c_reg.mono, c_reg.res[1], c_reg.res[0]}),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (buf_out)
    );

    // Outputs taken from registers
    assign out_l              = buf_out[23:0];
    assign out_r              = buf_out[47:24];
    assign mono_serial_output = buf_out[71:48];                              // [RULE_15]
    assign sample_ready       = c_reg.st[0];
    assign vol_ramping        = c_reg.ramping;
endmodule : agmt_top

/* File: tb/agmt_chk.sv */
// Port checker of the gain, mix and tone path
`timescale 1ns/100ps
module agmt_chk (
    // Clock and sample control
    input logic        clk_sys,
    input logic        rst,
    input logic        ce,
    input logic        fs_tick,
    input logic        sample_ready,
    // Output stream and status
    input logic        out_valid,
    input logic        out_ready,
    input logic [23:0] out_l,
    input logic [23:0] out_r,
    input logic [23:0] mono_serial_output,
    input logic        vol_ramping
);
    logic        took;
    logic [11:0] ramp_cnt;
    assign took = fs_tick && sample_ready && ce;
    // Samples taken during one ramp
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            ramp_cnt <= 12'h000;
        else if (!vol_ramping)
            ramp_cnt <= 12'h000;
        else if (took)
            ramp_cnt <= ramp_cnt + 12'h001;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    take_low_a: assert property (took |=> !sample_ready)
        else $error("input open after take");
    busy_span_a: assert property ($fell(sample_ready) |-> !sample_ready [*4])
        else $error("reopened early");
    push_time_a: assert property (took && !out_valid |-> ##5 out_valid)
        else $error("output word late");
    rise_cause_a: assert property ($rose(out_valid) |-> $past(took, 5))
        else $error("word without sample");
    word_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_l)
        && $stable(out_r) && $stable(mono_serial_output))
        else $error("stalled word changed");
    pop_only_a: assert property ($fell(out_valid) |-> $past(out_ready))
        else $error("word lost");
    reset_idle_a: assert property ($fell(rst) |-> sample_ready && !out_valid && !vol_ramping)
        else $error("bad reset state");
    ramp_len_a: assert property (ramp_cnt <= 12'h801)
        else $error("ramp too long");
endmodule : agmt_chk
bind agmt_top agmt_chk i_chk (.clk_sys, .rst, .ce, .fs_tick, .sample_ready, .out_valid,
    .out_ready, .out_l, .out_r, .mono_serial_output, .vol_ramping);

/* File: tb/agmt_host.sv */
// Control port master standing in for the external controller
`timescale 1ns/100ps
module agmt_host (
    // Clock
    input  logic       clk_sys,
    // Control byte stream
    output logic       cmd_start,
    output logic       cmd_valid,
    output logic [7:0] cmd_byte
);
    initial begin
        cmd_start = 1'b0;
        cmd_valid = 1'b0;
        cmd_byte  = 8'h00;
    end
    // One write: start, subaddress, payload MSB first
    task automatic send(input logic [7:0] sub, input int len, input logic [71:0] d);
        @(negedge clk_sys);
        cmd_start = 1'b1;
        @(negedge clk_sys);
        cmd_start = 1'b0;
        cmd_valid = 1'b1;
        cmd_byte  = sub;
        for (int i = len - 1; i >= 0; i--) begin
            @(negedge clk_sys);
            cmd_byte = d[8*i +: 8];
        end
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_byte  = ~cmd_byte;
    endtask : send
endmodule : agmt_host

/* File: tb/audio_gain_mix_tone_path_test.sv */
// Self-checking bench of the gain, mix and tone path
`timescale 1ns/100ps
`include "agmt_params.svh"
module audio_gain_mix_tone_path_test;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        fs_tick = 1'b0;
    logic        out_ready = 1'b1;
    logic [6:0]  pins = 7'h00;
    logic [23:0] din [6] = '{default: 24'h000000};
    logic        cmd_start, cmd_valid, sample_ready, out_valid, vol_ramping;
    logic [7:0]  cmd_byte;
    logic [23:0] out_l, out_r, mono_serial_output, lx;
    logic [71:0] exp_q [$];
    integer      seed = 18;
    int          err_count = 0;
    int          cmp_count = 0;

    always #5 clk_sys = ~clk_sys;
    agmt_host i_host (.clk_sys, .cmd_start, .cmd_valid, .cmd_byte);
    agmt_top i_dut (.clk_sys, .rst, .ce, .cmd_start, .cmd_valid, .cmd_byte, .fs_tick,
        .first_serial_input_l(din[0]), .first_serial_input_r(din[1]),
        .second_serial_input_l(din[2]), .second_serial_input_r(din[3]),
        .adc_l(din[4]), .adc_r(din[5]), .sample_ready, .general_purpose_input_pin(pins),
        .out_valid, .out_ready, .out_l, .out_r, .mono_serial_output, .vol_ramping);

    task automatic check(input logic [71:0] seen, input logic [71:0] want);
        cmp_count++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic finish_test();
        $display("cmp %0d err %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test
    function automatic logic [23:0] rnd();
        return 24'($random(seed) >>> 10);
    endfunction : rnd
    function automatic logic [23:0] half(input logic [23:0] a, input logic [23:0] b);
        return 24'(({a[23], a} + {b[23], b}) >> 1);
    endfunction : half
    task automatic roll();
        foreach (din[i]) din[i] = rnd();
    endtask : roll
    // Offer a sample, note its word
    task automatic smp(input logic [23:0] l, input logic [23:0] r, input logic [23:0] m);
        @(negedge clk_sys);
        repeat (200) if (!sample_ready) @(negedge clk_sys);
        if (!sample_ready) err_count++;
        fs_tick = 1'b1;
        exp_q.push_back({l, r, m});
        @(negedge clk_sys);
        fs_tick = 1'b0;
    endtask : smp
    // Silence until ramp ends
    task automatic settle();
        din = '{default: 24'h000000};
        repeat (4) smp(24'h0, 24'h0, 24'h0);
        repeat (2100) if (vol_ramping) smp(24'h0, 24'h0, 24'h0);
        check({71'h0, vol_ramping}, 72'h0);
    endtask : settle

    // Receiver stalls at random
    always @(negedge clk_sys) out_ready <= ($random(seed) & 3) != 0;
    // Oldest note per output word
    always @(posedge clk_sys) begin
        if (out_valid && out_ready) begin
            if (exp_q.size() == 0)
                check({out_l, out_r, mono_serial_output}, 72'hx);
            else
                check({out_l, out_r, mono_serial_output}, exp_q.pop_front());
        end
    end
    initial begin
        #900000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        // Reset mix: first input only
        repeat (4) begin
            roll();
            smp(din[0], din[1], half(din[0], din[1]));
        end
        // Left: second input at 1.0, converter at 0.5
        i_host.send(`AGMT_SUB_MIX_LEFT, 9, {24'h0, 24'h100000, 24'h080000});
        repeat (4) begin
            roll();
            lx = din[2] + {din[4][23], din[4][23:1]};
            smp(lx, din[1], half(lx, din[1]));
        end
        // Clipping sum
        i_host.send(`AGMT_SUB_MIX_LEFT, 9, {24'h100000, 24'h100000, 24'h0});
        din = '{24'h700000, 24'h000001, 24'h700000, 24'h0, 24'h0, 24'h0};
        smp(24'h7FFFFF, 24'h000001, 24'h400000);
        i_host.send(`AGMT_SUB_MIX_LEFT, 9, {24'h100000, 48'h0});
        // Zero volume
        i_host.send(`AGMT_SUB_VOLUME, 6, 72'h0);
        settle();
        roll();
        smp(24'h0, 24'h0, half(din[0], din[1]));
        // Balance
        i_host.send(`AGMT_SUB_VOLUME, 6, {24'h0, 24'h008000, 24'h010000});
        settle();
        roll();
        smp({din[0][23], din[0][23:1]}, din[1], half(din[0], din[1]));
        // Mute by pin, then command
        pins[`AGMT_PIN_MUTE] = 1'b1;
        settle();
        i_host.send(`AGMT_SUB_MUTE, 1, 72'h1);
        pins[`AGMT_PIN_MUTE] = 1'b0;
        settle();
        roll();
        smp(24'h0, 24'h0, half(din[0], din[1]));
        i_host.send(`AGMT_SUB_MUTE, 1, 72'h0);
        settle();
        roll();
        smp({din[0][23], din[0][23:1]}, din[1], half(din[0], din[1]));
        repeat (50) @(negedge clk_sys);
        check({40'h0, exp_q.size()}, 72'h0);
        finish_test();
    end
endmodule : audio_gain_mix_tone_path_test
